/* dpc_host_model.sv */
// Behavioural host driving the serial control port.
`default_nettype none
module dpc_host_model (
	// Serial control lines.
	output logic sclk_o,
	output logic sen_n_o,
	output logic sdata_o,
	output logic dsel_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle: clock parked low, port disabled, access select high.
	initial begin
		sclk_o = 1'b0;
		sen_n_o = 1'b1;
		sdata_o = 1'b0;
		dsel_o = 1'b1;
	end
	// One frame: address byte then nb data bits, MSB first, 30 ns clock.
	task automatic send(input logic [7:0] a, input int nb,
		input logic [223:0] d, input logic bad);
		logic [231:0] s;
		s = (232'(a) << nb) | 232'(d);
		#300;
		dsel_o = bad;
		sen_n_o = 1'b0;
		#15;
		for (int i = nb + 7; i >= 0; i--) begin
			sdata_o = s[i];
			#15 sclk_o = 1'b1;
			#15 sclk_o = 1'b0;
		end
		#15;
		sen_n_o = 1'b1;
		dsel_o = 1'b1;
		sdata_o = ~sdata_o;
	endtask : send
endmodule : dpc_host_model
`default_nettype wire

/* dpc_pkg.sv */
// Shared constants and types for the demodulator profile and coefficient store.
`default_nettype none
package dpc_pkg;

	// Serial frame layout: one address byte, then data words.
	localparam int ADDR_BITS = 8;
	localparam int REG_BITS = 16;
	localparam int PROF_BITS = 64;
	localparam int BLOCK_BITS = 112;
	localparam int CNT_W = 7;
	localparam logic [CNT_W-1:0] ADDR_LAST = 7'h07;
	localparam logic [CNT_W-1:0] REG_LAST = 7'h0f;
	localparam logic [CNT_W-1:0] PROF_LAST = 7'h3f;
	localparam logic [CNT_W-1:0] BLOCK_LAST = 7'h6f;

	// Address byte: two subchip enables on top, register offset below.
	localparam int SUBCHIP_LSB = 6;
	localparam int OFFS_W = 6;
	localparam logic [OFFS_W-1:0] OFFS_CONTROL = 6'h00;
	localparam logic [OFFS_W-1:0] OFFS_COEFF_PTR = 6'h06;
	localparam logic [OFFS_W-1:0] OFFS_COEFF_DATA = 6'h07;
	localparam logic [OFFS_W-1:0] OFFS_PROF_PTR = 6'h08;
	localparam logic [OFFS_W-1:0] OFFS_PROF_DATA = 6'h09;
	localparam logic [OFFS_W-1:0] OFFS_VECTOR_SEL = 6'h0e;
	localparam logic [OFFS_W-1:0] OFFS_MAN_START = 6'h1f;

	// Field positions inside 16-bit registers.
	localparam int TRIG_BIT = 2;
	localparam int VEC_LSB = 11;
	localparam int MAN_EN_BIT = 15;
	localparam int MAN_ADDR_LSB = 7;

	// Memory geometry.
	localparam int PROF_DEPTH = 32;
	localparam int PROF_AW = 5;
	localparam int BLOCK_DEPTH = 256;
	localparam int BLOCK_AW = 8;
	localparam int COEF_W = 14;
	localparam int COEF_PER_BLOCK = 8;
	localparam int POS_W = 3;
	localparam int DEC_W = 6;
	localparam int TAP_W = 9;
	localparam int START_SHIFT = 3;
	localparam int MIRROR_MUL = 16;
	localparam logic [REG_BITS-1:0] REG_RESET = 16'h0000;

	// One profile vector as stored.
	typedef struct packed {
		logic [27:0] reserved_hi;
		logic [7:0] coeff_ptr;
		logic [5:0] decim_factor;
		logic [15:0] down_freq;
		logic reserved_mid;
		logic [2:0] gain_comp;
		logic [1:0] ignored;
	} dpc_profile_type;

	// One finished serial word handed across the clock boundary.
	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic dig_sel;
		logic [BLOCK_BITS-1:0] data;
	} dpc_word_type;

	// Parameters the downstream datapath uses.
	typedef struct packed {
		logic [PROF_AW-1:0] vector;
		logic [BLOCK_AW-1:0] coeff_start;
		logic [DEC_W-1:0] decim_factor;
		logic [15:0] down_freq;
		logic [2:0] gain_comp;
	} dpc_active_type;

endpackage : dpc_pkg
`default_nettype wire

/* dpc_profile_coeff_ram.sv */
// Demodulator profile memory, coefficient memory and their serial write path.
`default_nettype none
module dpc_profile_coeff_ram #(
	parameter bit SUBCHIP = 1'b0
) (
	// Sampling clock domain.
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// Serial control port, clocked by the host.
	input wire logic serial_clk_i,
	input wire logic serial_port_enable_n_i,
	input wire logic serial_data_i,
	input wire logic digital_access_select_i,
	// Transmit sync pin.
	input wire logic tx_sync_i,
	// Coefficient tap request from the filter datapath.
	input wire logic tap_req_i,
	input wire logic [dpc_pkg::DEC_W-1:0] tap_block_i,
	input wire logic [dpc_pkg::POS_W-1:0] tap_pos_i,
	// Applied parameters.
	output logic [dpc_pkg::PROF_AW-1:0] active_vector_number_o,
	output logic [dpc_pkg::BLOCK_AW-1:0] coeff_start_o,
	output logic [dpc_pkg::DEC_W-1:0] decim_factor_o,
	output logic [15:0] down_freq_o,
	output logic [2:0] gain_comp_o,
	output logic trigger_o,
	// Coefficient tap answer.
	output logic tap_valid_o,
	output logic signed [dpc_pkg::COEF_W-1:0] tap_coeff_o,
	output logic [dpc_pkg::TAP_W-1:0] tap_number_o,
	output logic [dpc_pkg::TAP_W-1:0] tap_mirror_o
);

	// Serial clock domain state.
	logic frame_clr_n;
	logic addr_done;
	logic [dpc_pkg::CNT_W-1:0] bit_cnt;
	logic [dpc_pkg::ADDR_BITS-1:0] ser_addr;
	logic ser_dsel;
	logic [dpc_pkg::BLOCK_BITS-1:0] ser_shift;
	logic [dpc_pkg::CNT_W-1:0] word_last;
	logic word_done;
	logic [dpc_pkg::BLOCK_BITS-1:0] next_shift;
	dpc_pkg::dpc_word_type hold_word;
	logic hold_toggle;

	// Sampling clock domain state.
	logic tog_s1;
	logic tog_s2;
	logic tog_s3;
	logic word_event;
	logic sync_s1;
	logic sync_s2;
	logic sync_s3;
	logic write_hit;
	logic [dpc_pkg::OFFS_W-1:0] offs;
	logic manual_trig;
	logic trigger;
	logic [dpc_pkg::REG_BITS-1:0] coeff_wr_ptr;
	logic [dpc_pkg::REG_BITS-1:0] prof_wr_ptr;
	logic [dpc_pkg::REG_BITS-1:0] vector_sel;
	logic [dpc_pkg::REG_BITS-1:0] man_start;
	dpc_pkg::dpc_profile_type prof_mem [dpc_pkg::PROF_DEPTH];
	logic [dpc_pkg::BLOCK_BITS-1:0] coeff_mem [dpc_pkg::BLOCK_DEPTH];
	dpc_pkg::dpc_profile_type sel_prof;
	logic [dpc_pkg::BLOCK_AW-1:0] next_start;
	logic [dpc_pkg::BLOCK_AW-1:0] rd_block;
	logic [dpc_pkg::BLOCK_BITS-1:0] rd_word;
	logic [dpc_pkg::COEF_W-1:0] coef_lane [dpc_pkg::COEF_PER_BLOCK];
	logic [dpc_pkg::TAP_W-1:0] next_tap;
	logic [dpc_pkg::TAP_W-1:0] next_mirror;
	logic [dpc_pkg::PROF_AW-1:0] pend_vector;
	logic man_start_en;
	logic [dpc_pkg::BLOCK_AW-1:0] man_start_addr;
	// Decoded register writes, at most one per finished word.
	logic wr_control;
	logic wr_coeff_ptr;
	logic wr_coeff_data;
	logic wr_prof_ptr;
	logic wr_prof_data;
	logic wr_vector_sel;
	logic wr_man_start;

	// The frame logic is cleared whenever the enable is high, so a stopped
	// serial clock between frames leaves nothing half done.
	assign frame_clr_n = reset_n_i & ~serial_port_enable_n_i;

	// Word length follows the addressed register.
	always_comb begin
		if (ser_addr[dpc_pkg::OFFS_W-1:0] == dpc_pkg::OFFS_COEFF_DATA) begin
			word_last = dpc_pkg::BLOCK_LAST;
		end else if (ser_addr[dpc_pkg::OFFS_W-1:0] == dpc_pkg::OFFS_PROF_DATA) begin
			word_last = dpc_pkg::PROF_LAST;
		end else begin
			word_last = dpc_pkg::REG_LAST;
		end
	end

	// Data shifts in most significant bit first.
	assign next_shift = {ser_shift[dpc_pkg::BLOCK_BITS-2:0], serial_data_i};
	assign word_done = addr_done && (bit_cnt == word_last);

	// Frame sequencer: address byte, then back to back data words.
	always_ff @(posedge serial_clk_i or negedge frame_clr_n) begin
		if (!frame_clr_n) begin
			addr_done <= 1'b0;
			bit_cnt <= '0;
			ser_addr <= '0;
			ser_shift <= '0;
		end else if (!addr_done) begin
			ser_addr <= {ser_addr[dpc_pkg::ADDR_BITS-2:0], serial_data_i};
			addr_done <= (bit_cnt == dpc_pkg::ADDR_LAST);
			bit_cnt <= (bit_cnt == dpc_pkg::ADDR_LAST) ? '0 : bit_cnt + 1'b1;
		end else begin
			ser_shift <= next_shift;
			bit_cnt <= word_done ? '0 : bit_cnt + 1'b1;
		end
	end

	// Any high access select during the frame marks it as not ours.
	always_ff @(posedge serial_clk_i or negedge frame_clr_n) begin
		if (!frame_clr_n) begin
			ser_dsel <= 1'b0;
		end else begin
			ser_dsel <= ser_dsel | digital_access_select_i;
		end
	end

	// Finished words are parked here and announced by a toggle.
	always_ff @(posedge serial_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			hold_word <= '0;
			hold_toggle <= 1'b0;
		end else if (word_done) begin
			hold_word.addr <= ser_addr;
			hold_word.dig_sel <= ser_dsel | digital_access_select_i;
			hold_word.data <= next_shift;
			hold_toggle <= ~hold_toggle;
		end
	end

	// Toggle crossing into the sampling clock domain.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tog_s1 <= 1'b0;
			tog_s2 <= 1'b0;
			tog_s3 <= 1'b0;
		end else begin
			tog_s1 <= hold_toggle;
			tog_s2 <= tog_s1;
			tog_s3 <= tog_s2;
		end
	end

	assign word_event = tog_s2 ^ tog_s3;
	assign offs = hold_word.addr[dpc_pkg::OFFS_W-1:0];
	// A word counts when this subchip is enabled and access select was low.
	assign write_hit = word_event && !hold_word.dig_sel &&
		hold_word.addr[dpc_pkg::SUBCHIP_LSB + int'(SUBCHIP)];

	// Transmit sync pin synchroniser and rising edge detector.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			sync_s1 <= 1'b0;
			sync_s2 <= 1'b0;
			sync_s3 <= 1'b0;
		end else begin
			sync_s1 <= tx_sync_i;
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
		end
	end

	// Register decode: one strobe per mapped offset, others are dropped.
	always_comb begin
		wr_control = 1'b0;
		wr_coeff_ptr = 1'b0;
		wr_coeff_data = 1'b0;
		wr_prof_ptr = 1'b0;
		wr_prof_data = 1'b0;
		wr_vector_sel = 1'b0;
		wr_man_start = 1'b0;
		if (write_hit) begin
			if (offs == dpc_pkg::OFFS_CONTROL) begin
				wr_control = 1'b1;
			end else if (offs == dpc_pkg::OFFS_COEFF_PTR) begin
				wr_coeff_ptr = 1'b1;
			end else if (offs == dpc_pkg::OFFS_COEFF_DATA) begin
				wr_coeff_data = 1'b1;
			end else if (offs == dpc_pkg::OFFS_PROF_PTR) begin
				wr_prof_ptr = 1'b1;
			end else if (offs == dpc_pkg::OFFS_PROF_DATA) begin
				wr_prof_data = 1'b1;
			end else if (offs == dpc_pkg::OFFS_VECTOR_SEL) begin
				wr_vector_sel = 1'b1;
			end else if (offs == dpc_pkg::OFFS_MAN_START) begin
				wr_man_start = 1'b1;
			end
		end
	end

	// The manual trigger bit acts once and is not stored.
	assign manual_trig = wr_control && hold_word.data[dpc_pkg::TRIG_BIT];
	assign trigger = (sync_s2 && !sync_s3) || manual_trig;

	// Coefficient write pointer, advancing after each block.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			coeff_wr_ptr <= dpc_pkg::REG_RESET;
		end else if (wr_coeff_ptr) begin
			coeff_wr_ptr <= hold_word.data[dpc_pkg::REG_BITS-1:0];
		end else if (wr_coeff_data) begin
			coeff_wr_ptr[dpc_pkg::BLOCK_AW-1:0] <=
				coeff_wr_ptr[dpc_pkg::BLOCK_AW-1:0] + 1'b1;
		end
	end

	// Profile write pointer, advancing after each entry.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			prof_wr_ptr <= dpc_pkg::REG_RESET;
		end else if (wr_prof_ptr) begin
			prof_wr_ptr <= hold_word.data[dpc_pkg::REG_BITS-1:0];
		end else if (wr_prof_data) begin
			prof_wr_ptr[dpc_pkg::PROF_AW-1:0] <=
				prof_wr_ptr[dpc_pkg::PROF_AW-1:0] + 1'b1;
		end
	end

	// Pending vector index and manual start settings.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			vector_sel <= dpc_pkg::REG_RESET;
			man_start <= dpc_pkg::REG_RESET;
		end else if (wr_vector_sel) begin
			vector_sel <= hold_word.data[dpc_pkg::REG_BITS-1:0];
		end else if (wr_man_start) begin
			man_start <= hold_word.data[dpc_pkg::REG_BITS-1:0];
		end
	end

	// Memories have no reset; their contents are whatever was written.
	always_ff @(posedge mclk_i) begin
		if (wr_prof_data) begin
			prof_mem[prof_wr_ptr[dpc_pkg::PROF_AW-1:0]] <=
				hold_word.data[dpc_pkg::PROF_BITS-1:0];
		end
	end

	// Coefficient blocks land at the write pointer and are never reset.
	always_ff @(posedge mclk_i) begin
		if (wr_coeff_data) begin
			coeff_mem[coeff_wr_ptr[dpc_pkg::BLOCK_AW-1:0]] <=
				hold_word.data;
		end
	end

	// Fields of the pending selection registers.
	assign pend_vector = vector_sel[dpc_pkg::REG_BITS-1:dpc_pkg::VEC_LSB];
	assign man_start_en = man_start[dpc_pkg::MAN_EN_BIT];
	assign man_start_addr =
		man_start[dpc_pkg::MAN_EN_BIT-1:dpc_pkg::MAN_ADDR_LSB];

	// The profile chosen by the pending index, and the start block: the manual one if enabled, else the profile's.
	assign sel_prof = prof_mem[pend_vector];
	always_comb begin
		if (man_start_en) begin
			next_start = man_start_addr;
		end else begin
			next_start = sel_prof.coeff_ptr;
		end
	end

	// Applied parameters switch only on a trigger.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			active_vector_number_o <= '0;
			coeff_start_o <= '0;
			decim_factor_o <= '0;
			down_freq_o <= '0;
			gain_comp_o <= '0;
		end else if (trigger) begin
			active_vector_number_o <= pend_vector;
			coeff_start_o <= next_start;
			decim_factor_o <= sel_prof.decim_factor;
			down_freq_o <= sel_prof.down_freq;
			gain_comp_o <= sel_prof.gain_comp;
		end
	end

	// One-cycle trigger indication for the datapath.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			trigger_o <= 1'b0;
		end else begin
			trigger_o <= trigger;
		end
	end

	// Block holding phase j: start block times eight, plus j, wrapping.
	assign rd_block = BLOCK_AW_CAST(
		{coeff_start_o, {dpc_pkg::START_SHIFT{1'b0}}} + tap_block_i);
	assign rd_word = coeff_mem[rd_block];

	// Split the block into its eight coefficient lanes.
	generate
		for (genvar k = 0; k < dpc_pkg::COEF_PER_BLOCK; k++) begin : g_lane
			assign coef_lane[k] =
				rd_word[k*dpc_pkg::COEF_W +: dpc_pkg::COEF_W];
		end
	endgenerate

	// Tap number of this coefficient and of its mirror image.
	assign next_tap = TAP_CAST(decim_factor_o * ({6'h00, tap_pos_i} + 1'b1)
		- ({3'h0, tap_block_i} + 1'b1));
	assign next_mirror = TAP_CAST(decim_factor_o * dpc_pkg::MIRROR_MUL
		- 1 - next_tap);

	// Registered tap answer, one cycle after the request.
	always_ff @(posedge mclk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			tap_valid_o <= 1'b0;
			tap_coeff_o <= '0;
			tap_number_o <= '0;
			tap_mirror_o <= '0;
		end else begin
			tap_valid_o <= tap_req_i;
			if (tap_req_i) begin
				tap_coeff_o <= signed'(coef_lane[tap_pos_i]);
				tap_number_o <= next_tap;
				tap_mirror_o <= next_mirror;
			end
		end
	end

	// Keeps the low address bits, so the block number wraps at 256.
	function automatic logic [dpc_pkg::BLOCK_AW-1:0] BLOCK_AW_CAST(
		input logic [31:0] v
	);
		BLOCK_AW_CAST = v[dpc_pkg::BLOCK_AW-1:0];
	endfunction : BLOCK_AW_CAST

	// Keeps the low tap bits of a wide unsigned intermediate result.
	function automatic logic [dpc_pkg::TAP_W-1:0] TAP_CAST(
		input logic [31:0] v
	);
		TAP_CAST = v[dpc_pkg::TAP_W-1:0];
	endfunction : TAP_CAST

endmodule : dpc_profile_coeff_ram
`default_nettype wire

/* dpc_ram_props_properties.sv */
// Port assertions for the profile and coefficient store.
`default_nettype none
module dpc_ram_props (
	// Clock, reset and inputs.
	input wire logic mclk_i,
	input wire logic reset_n_i,
	input wire logic tx_sync_i,
	input wire logic tap_req_i,
	input wire logic [5:0] tap_block_i,
	input wire logic [2:0] tap_pos_i,
	// Applied parameters and tap answer.
	input wire logic [4:0] active_vector_number_o,
	input wire logic [7:0] coeff_start_o,
	input wire logic [5:0] decim_factor_o,
	input wire logic [15:0] down_freq_o,
	input wire logic [2:0] gain_comp_o,
	input wire logic trigger_o,
	input wire logic tap_valid_o,
	input wire logic signed [13:0] tap_coeff_o,
	input wire logic [8:0] tap_number_o,
	input wire logic [8:0] tap_mirror_o
);
	// All applied parameters gathered into one vector.
	wire logic [37:0] applied = {active_vector_number_o, coeff_start_o,
		decim_factor_o, down_freq_o, gain_comp_o};
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!reset_n_i);
	a_tap_answer: assert property (tap_req_i |=> tap_valid_o)
		else $error("tap request not answered");
	a_tap_quiet: assert property (!tap_req_i |=> !tap_valid_o)
		else $error("tap answer without request");
	a_tap_number: assert property (tap_req_i |=> tap_number_o ==
		$past(decim_factor_o) * ($past(tap_pos_i) + 9'h001)
		- $past(tap_block_i) - 9'h001)
		else $error("tap number wrong");
	a_tap_mirror: assert property (tap_req_i |=> tap_mirror_o ==
		9'h010 * $past(decim_factor_o) - 9'h001 - tap_number_o)
		else $error("mirror number wrong");
	a_tap_hold: assert property (!tap_valid_o |->
		$stable({tap_coeff_o, tap_number_o, tap_mirror_o}))
		else $error("tap answer moved without request");
	a_param_trig: assert property ($changed(applied) |-> trigger_o)
		else $error("parameters changed without trigger");
	a_trig_pulse: assert property (trigger_o |=> !trigger_o)
		else $error("trigger pulse too long");
	a_sync_trig: assert property (
		$rose(tx_sync_i) |-> ##[2:6] trigger_o)
		else $error("sync edge gave no trigger");
	// Main scenarios reached.
	c_burst: cover property (tap_req_i ##1 tap_req_i ##1 tap_valid_o);
	c_sync: cover property ($rose(tx_sync_i) ##[2:6] trigger_o);
	c_manual: cover property (trigger_o && !tx_sync_i);
endmodule : dpc_ram_props
bind dpc_profile_coeff_ram dpc_ram_props u_props (.mclk_i, .reset_n_i,
	.tx_sync_i, .tap_req_i, .tap_block_i, .tap_pos_i,
	.active_vector_number_o, .coeff_start_o, .decim_factor_o, .down_freq_o,
	.gain_comp_o, .trigger_o, .tap_valid_o, .tap_coeff_o, .tap_number_o,
	.tap_mirror_o);
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the profile and coefficient store.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic sclk, sen_n, sdat, dsel, trg, tv;
	logic sync, req;
	logic [5:0] blk, dec;
	logic [2:0] pos, gn, g;
	logic [4:0] vec, idx;
	logic [7:0] cst, p, man;
	logic [15:0] frq, f;
	logic signed [13:0] tc;
	logic [8:0] tn, tm, n;
	logic [13:0] c;
	logic [111:0] coef [2];
	logic [63:0] e0, e1;
	int mismatches = 0;
	int n_checks = 0;
	// Sampling clock at 25 MHz.
	always #20 mclk = ~mclk;
	dpc_profile_coeff_ram u_dut (.mclk_i(mclk), .reset_n_i(rst_n),
		.serial_clk_i(sclk), .serial_port_enable_n_i(sen_n),
		.serial_data_i(sdat), .digital_access_select_i(dsel),
		.tx_sync_i(sync), .tap_req_i(req), .tap_block_i(blk),
		.tap_pos_i(pos), .active_vector_number_o(vec), .coeff_start_o(cst),
		.decim_factor_o(dec), .down_freq_o(frq), .gain_comp_o(gn),
		.trigger_o(trg), .tap_valid_o(tv), .tap_coeff_o(tc),
		.tap_number_o(tn), .tap_mirror_o(tm));
	dpc_host_model u_host (.sclk_o(sclk), .sen_n_o(sen_n), .sdata_o(sdat),
		.dsel_o(dsel));
	// Compare and count.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// Counts, verdict, stop.
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test
	// Bounded wait for the trigger pulse.
	task automatic wait_trig;
		int k;
		k = 0;
		while (trg !== 1'b1 && k < 60) begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (trg !== 1'b1) begin
			$display("ERROR %0t: trigger pulse never seen", $time);
			mismatches++;
			end_of_test();
		end
	endtask : wait_trig
	// Profile word with reserved bits zero and ignored bits set.
	function automatic logic [63:0] prof(logic [7:0] pp, logic [5:0] m,
		logic [15:0] ff, logic [2:0] gg);
		return {28'h0, pp, m, ff, 1'b0, gg, 2'h3};
	endfunction : prof
	function automatic logic [8:0] tnum(int m, int i, int j);
		return 9'(m * (1 + i) - (1 + j));
	endfunction : tnum
	// Main sequence.
	initial begin
		{sync, req, blk, pos} = '0;
		void'($urandom(32'h1510e80b));
		repeat (4) @(posedge mclk);
		#1 rst_n = 1'b1;
		p = 8'($urandom);
		f = 16'($urandom);
		g = 3'($urandom);
		idx = 5'($urandom) & 5'h1e;
		coef[0] = 112'({$urandom, $urandom, $urandom, $urandom});
		coef[1] = 112'({$urandom, $urandom, $urandom, $urandom});
		e0 = prof(8'($urandom), 6'($urandom), 16'($urandom), 3'($urandom));
		e1 = prof(p, 6'h02, f, g);
		u_host.send(8'hc6, 16, 224'({p[4:0], 3'h0}), 1'b0);
		u_host.send(8'hc7, 112, 224'(coef[0]), 1'b0);
		u_host.send(8'hc7, 112, 224'(coef[1]), 1'b0);
		u_host.send(8'hc8, 16, 224'(idx), 1'b0);
		u_host.send(8'hc9, 128, 224'({e0, e1}), 1'b0);
		u_host.send(8'hce, 16, 224'({idx + 5'h1, 11'h0}), 1'b0);
		repeat (8) @(posedge mclk);
		#1;
		chk(cst, 0);
		chk(dec, 0);
		u_host.send(8'hc0, 16, 224'(16'h0004), 1'b0);
		wait_trig();
		chk(vec, idx + 5'h1);
		chk(cst, p);
		chk(dec, 2);
		chk(frq, f);
		chk(gn, e1[4:2]);
		$display("test manual trigger done");
		// Back-to-back tap reads, each answer checked one cycle later.
		for (int t = 0; t <= 16; t++) begin
			@(posedge mclk);
			#1;
			if (t > 0) begin
				c = coef[blk[0]][pos * 14 +: 14];
				n = tnum(2, pos, blk);
				chk(tv, 1);
				chk(tc, {{18{c[13]}}, c});
				chk(tn, n);
				chk(tm, 9'd31 - n);
			end
			req = (t < 16);
			blk = 6'(t / 8);
			pos = 3'(t % 8);
		end
		$display("test tap reads done");
		man = 8'($urandom);
		u_host.send(8'hdf, 16, 224'({1'b1, man, 7'h00}), 1'b0);
		u_host.send(8'hce, 16, 224'({idx, 11'h0}), 1'b0);
		u_host.send(8'h8e, 16, 224'({~idx, 11'h0}), 1'b0);
		u_host.send(8'hce, 16, 224'({~idx, 11'h0}), 1'b1);
		@(posedge mclk);
		#1 sync = 1'b1;
		wait_trig();
		sync = 1'b0;
		chk(vec, idx);
		chk(cst, man);
		chk(dec, e0[27:22]);
		chk(frq, e0[21:6]);
		chk(gn, e0[4:2]);
		$display("test sync trigger done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
